// ### hdl/wavegen_cfg_pkg.sv
// shared constants, field layouts and carrier types of the waveform generator config bank
package wavegen_cfg_pkg;

    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;                       // register address width
    localparam int DATA_W = 16;                      // register data width
    localparam int SMP_W  = 12;                      // sample width on the gain path

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_MAIN_CTRL  = 8'h00;   // holds the marker enable bit
    localparam logic [7:0] OFS_STATUS     = 8'h01;   // read-only block state
    localparam logic [7:0] OFS_WAVE_SEL   = 8'h27;   // prestored waveform selector
    localparam logic [7:0] OFS_MARK_START = 8'h2c;   // trigger to marker-high delay
    localparam logic [7:0] OFS_MARK_CFG   = 8'h2d;   // marker_output_config
    localparam logic [7:0] OFS_CONST      = 8'h31;   // dac_constant_value
    localparam logic [7:0] OFS_GAIN       = 8'h35;   // dac_gain_word
    localparam logic [7:0] OFS_SAW        = 8'h37;   // sawtooth_config
    localparam logic [7:0] OFS_TW_HI      = 8'h3e;   // tuning_word_upper
    localparam logic [7:0] OFS_TW_LO      = 8'h3f;   // tuning_word_lower
    localparam logic [7:0] OFS_PHASE      = 8'h43;   // phase_offset_word
    localparam logic [7:0] OFS_PAT_CTRL   = 8'h44;   // pattern_control_one

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int MARK_EN_BIT    = 0;               // in main control
    localparam int MARK_LEVEL_BIT = 5;               // manual marker level
    localparam int MARK_MODE_BIT  = 4;               // 0 manual, 1 timed
    localparam int MARK_STOP_LSB  = 0;               // stop delay [3:0]
    localparam int PRESTORE_LSB   = 4;               // selector [5:4]
    localparam int CONST_LSB      = 4;               // constant [15:4]
    localparam int GAIN_LSB       = 4;               // gain [15:4]
    localparam int STEP_LSB       = 2;               // ramp step [7:2]
    localparam int SHAPE_LSB      = 0;               // ramp shape [1:0]
    localparam int TW_LO_LSB      = 8;               // tuning low [15:8]
    localparam int FIRST_ONLY_BIT = 1;               // delay only before first pattern
    localparam int GAIN_FRAC      = 10;              // gain is s1.10, range about +2..-2

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_MARK_START = 16'h0003;
    localparam logic [3:0]  RST_MARK_STOP  = 4'h0;
    localparam logic [11:0] RST_CONST      = 12'h000;
    localparam logic [11:0] RST_GAIN       = 12'h000;
    localparam logic [5:0]  RST_STEP       = 6'h01;
    localparam logic [15:0] RST_TW_HI      = 16'h0000;
    localparam logic [7:0]  RST_TW_LO      = 8'h00;
    localparam logic [15:0] RST_PHASE      = 16'h0000;
    localparam logic [15:0] RST_LFSR       = 16'hace1;   // any nonzero seed

    // ------------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PRE_CONST = 2'b00, PRE_RAMP = 2'b01, PRE_NOISE = 2'b10, PRE_SYNTH = 2'b11
    } prestore_t;

    typedef enum logic [1:0] {
        RAMP_UP = 2'b00, RAMP_DOWN = 2'b01, RAMP_TRI = 2'b10, RAMP_ZERO = 2'b11
    } ramp_shape_t;

    typedef enum logic [1:0] {
        MK_LOW = 2'b00, MK_START_WAIT = 2'b01, MK_HIGH = 2'b10, MK_STOP_WAIT = 2'b11
    } marker_state_t;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [23:0] tuning_word;                    // {hi, lo} to the synthesizer
        logic [15:0] phase_offset;                   // phase offset to the synthesizer
    } synth_ctrl_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;                     // register address
        logic [DATA_W-1:0] wdata;                    // write data
        logic              wr;                       // write strobe
        logic              rd;                       // read strobe
    } reg_req_t;

endpackage

// ### hdl/waveform_gen_config_regs.sv
// configuration register bank, prestored wave source, gain stage and marker timing
//
// Functional notes
// [R1] manual level bit applies only in manual mode
// [R2] mode 0: marker follows manual level bit
// [R3] mode 1: marker timed by start/stop delays
// [R4] marker low stop-delay cycles after pattern end
// [R5] marker high start-delay cycles after trigger low
// [R6] 12-bit constant in [15:4], output when selected
// [R7] selector: constant, sawtooth, pseudorandom, synthesizer
// [R8] 12-bit gain scales samples, about +2..-2
// [R9] ramp holds each step for 6-bit count
// [R10] ramp shape: up, down, triangle, zero
// [R11] tuning word upper 16 bits, reset zero
// [R12] tuning word lower 8 bits in [15:8]
// [R13] phase offset from 16-bit register
// [R14] start delay every pattern or first only
// [R15] marker held low while enable clear
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps

module waveform_gen_config_regs (
    input  wire logic                              CLOCK,
    input  wire logic                              RST_B,
    input  wire wavegen_cfg_pkg::reg_req_t         REG_REQ,
    output logic [wavegen_cfg_pkg::DATA_W-1:0]     RDATA,
    input  wire logic                              TRIGGER_B,
    input  wire logic                              PATTERN_END,
    input  wire logic [wavegen_cfg_pkg::SMP_W-1:0] SYNTH_SAMPLE,
    output logic [wavegen_cfg_pkg::SMP_W-1:0]      SAMPLE_OUT,
    output wavegen_cfg_pkg::synth_ctrl_t           SYNTH_CTRL,
    output logic                                   START_DELAY_EN,
    output logic                                   MARKER_OUT,
    output logic                                   MARKER_OE
);
    import wavegen_cfg_pkg::*;

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic          mark_en_q;          // marker enable
    logic          mark_level_q;       // manual marker level
    logic          mark_mode_q;        // 0 manual, 1 timed
    logic [3:0]    mark_stop_q;        // pattern end to marker low
    logic [15:0]   mark_start_q;       // trigger low to marker high
    prestore_t     prestore_q;         // prestored wave selector
    logic [11:0]   const_q;            // constant sample
    logic [11:0]   gain_q;             // signed s1.10 gain
    logic [5:0]    step_q;             // samples per ramp step
    ramp_shape_t   shape_q;            // ramp shape
    logic [15:0]   tw_hi_q;            // tuning word upper part
    logic [7:0]    tw_lo_q;            // tuning word lower part
    logic [15:0]   phase_q;            // phase offset
    logic          first_only_q;       // start delay before first pattern only

    // ------------------------------------------------------------------
    // block state
    // ------------------------------------------------------------------
    logic [2:0]    trig_sync_q;        // trigger synchroniser, stage 0 is the raw catch
    logic          trig_low_q;         // debounced trigger level, high means low pin
    logic          trig_fall;          // one-cycle pulse on trigger going low
    marker_state_t mk_state_q;         // timed marker sequencer
    logic [15:0]   mk_cnt_q;           // delay counter of the sequencer
    logic          mk_timed_q;         // timed marker level
    logic          first_pend_q;       // first pattern after trigger not yet done
    logic [5:0]    hold_cnt_q;         // samples spent on current ramp step
    logic [11:0]   ramp_q;             // ramp amplitude
    logic          ramp_dn_q;          // triangle direction, 1 means falling
    logic [15:0]   lfsr_q;             // pseudorandom generator
    logic [11:0]   src_q;              // selected source sample
    logic [23:0]   product;            // signed sample times gain
    logic [13:0]   scaled;             // product with fraction dropped
    logic [11:0]   sat_d;              // saturated gain stage result
    logic [5:0]    step_eff;           // step count, zero treated as one
    logic          step_done;          // current ramp step has ended

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // reserved bits are not stored, so they read back as zero
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            mark_en_q    <= 1'b0;
            mark_level_q <= 1'b0;
            mark_mode_q  <= 1'b0;
            mark_stop_q  <= RST_MARK_STOP;
            mark_start_q <= RST_MARK_START;
            prestore_q   <= PRE_CONST;
            const_q      <= RST_CONST;
            gain_q       <= RST_GAIN;
            step_q       <= RST_STEP;
            shape_q      <= RAMP_UP;
            tw_hi_q      <= RST_TW_HI;
            tw_lo_q      <= RST_TW_LO;
            phase_q      <= RST_PHASE;
            first_only_q <= 1'b0;
        end else if (REG_REQ.wr) begin
            case (REG_REQ.addr)
                OFS_MAIN_CTRL: begin
                    mark_en_q <= REG_REQ.wdata[MARK_EN_BIT];
                end
                OFS_MARK_CFG: begin
                    mark_level_q <= REG_REQ.wdata[MARK_LEVEL_BIT];
                    mark_mode_q  <= REG_REQ.wdata[MARK_MODE_BIT];
                    mark_stop_q  <= REG_REQ.wdata[MARK_STOP_LSB +: 4]; // R4
                end
                OFS_MARK_START: begin
                    mark_start_q <= REG_REQ.wdata; // R5
                end
                OFS_WAVE_SEL: begin
                    prestore_q <= prestore_t'(REG_REQ.wdata[PRESTORE_LSB +: 2]); // R7
                end
                OFS_CONST: begin
                    const_q <= REG_REQ.wdata[CONST_LSB +: 12]; // R6
                end
                OFS_GAIN: begin
                    gain_q <= REG_REQ.wdata[GAIN_LSB +: 12]; // R8
                end
                OFS_SAW: begin
                    step_q  <= REG_REQ.wdata[STEP_LSB +: 6]; // R9
                    shape_q <= ramp_shape_t'(REG_REQ.wdata[SHAPE_LSB +: 2]); // R10
                end
                OFS_TW_HI: begin
                    tw_hi_q <= REG_REQ.wdata; // R11
                end
                OFS_TW_LO: begin
                    tw_lo_q <= REG_REQ.wdata[TW_LO_LSB +: 8]; // R12
                end
                OFS_PHASE: begin
                    phase_q <= REG_REQ.wdata; // R13
                end
                OFS_PAT_CTRL: begin
                    first_only_q <= REG_REQ.wdata[FIRST_ONLY_BIT]; // R14
                end
                default: begin
                    // unmapped write is ignored
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------------
    // data stand only in the cycle after the strobe; zero otherwise and when unmapped
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            RDATA <= 16'h0000;
        end else if (REG_REQ.rd) begin
            case (REG_REQ.addr)
                OFS_MAIN_CTRL:  RDATA <= 16'(mark_en_q);
                OFS_STATUS:     RDATA <= {11'h000, first_pend_q, trig_low_q,
                                          mk_state_q, MARKER_OUT};
                OFS_MARK_CFG:   RDATA <= {10'h000, mark_level_q, mark_mode_q, mark_stop_q};
                OFS_MARK_START: RDATA <= mark_start_q;
                OFS_WAVE_SEL:   RDATA <= {10'h000, prestore_q, 4'h0};
                OFS_CONST:      RDATA <= {const_q, 4'h0};
                OFS_GAIN:       RDATA <= {gain_q, 4'h0};
                OFS_SAW:        RDATA <= {8'h00, step_q, shape_q};
                OFS_TW_HI:      RDATA <= tw_hi_q;
                OFS_TW_LO:      RDATA <= {tw_lo_q, 8'h00};
                OFS_PHASE:      RDATA <= phase_q;
                OFS_PAT_CTRL:   RDATA <= {14'h0000, first_only_q, 1'b0};
                default:        RDATA <= 16'h0000;
            endcase
        end else begin
            RDATA <= 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // trigger pin synchroniser
    // ------------------------------------------------------------------
    // three stages; the level only changes once stages one and two agree
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            trig_sync_q <= 3'b111;
            trig_low_q  <= 1'b0;
        end else begin
            trig_sync_q <= {trig_sync_q[1:0], TRIGGER_B};
            if (trig_sync_q[1] == trig_sync_q[2]) begin
                trig_low_q <= ~trig_sync_q[2];
            end
        end
    end

    assign trig_fall = (trig_sync_q[1] == trig_sync_q[2]) && !trig_sync_q[2] && !trig_low_q;

    // ------------------------------------------------------------------
    // timed marker sequencer
    // ------------------------------------------------------------------
    // a new trigger restarts the start wait from any state
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            mk_state_q <= MK_LOW;
            mk_cnt_q   <= 16'h0000;
            mk_timed_q <= 1'b0;
        end else if (trig_fall) begin
            mk_state_q <= MK_START_WAIT;
            mk_cnt_q   <= mark_start_q;
        end else begin
            case (mk_state_q)
                MK_START_WAIT: begin
                    // count the start delay down, then raise
                    if (mk_cnt_q == 16'h0000) begin
                        mk_state_q <= MK_HIGH;
                        mk_timed_q <= 1'b1; // R5
                    end else begin
                        mk_cnt_q <= mk_cnt_q - 16'h0001;
                    end
                end
                MK_HIGH: begin
                    // wait for the pattern to end
                    if (PATTERN_END) begin
                        mk_state_q <= MK_STOP_WAIT;
                        mk_cnt_q   <= {12'h000, mark_stop_q};
                    end
                end
                MK_STOP_WAIT: begin
                    // count the stop delay down, then drop
                    if (mk_cnt_q == 16'h0000) begin
                        mk_state_q <= MK_LOW;
                        mk_timed_q <= 1'b0; // R4
                    end else begin
                        mk_cnt_q <= mk_cnt_q - 16'h0001;
                    end
                end
                default: begin
                    mk_state_q <= MK_LOW;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // marker pin
    // ------------------------------------------------------------------
    // the pin is shared with serial data out, so it is only driven while enabled
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            MARKER_OUT <= 1'b0;
        end else if (!mark_en_q) begin
            MARKER_OUT <= 1'b0; // R15
        end else if (mark_mode_q) begin
            MARKER_OUT <= mk_timed_q; // R3
        end else begin
            MARKER_OUT <= mark_level_q; // R1 R2
        end
    end

    assign MARKER_OE = mark_en_q; // R2 R3

    // ------------------------------------------------------------------
    // start delay policy
    // ------------------------------------------------------------------
    // pending from a trigger until the first pattern ends; trigger wins a tie
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            first_pend_q <= 1'b0;
        end else if (trig_fall) begin
            first_pend_q <= 1'b1;
        end else if (PATTERN_END) begin
            first_pend_q <= 1'b0;
        end
    end

    assign START_DELAY_EN = !first_only_q || first_pend_q; // R14

    // ------------------------------------------------------------------
    // sawtooth generator
    // ------------------------------------------------------------------
    assign step_eff  = (step_q == 6'h00) ? 6'h01 : step_q;
    assign step_done = (hold_cnt_q + 6'h01) >= step_eff;

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            hold_cnt_q <= 6'h00;
            ramp_q     <= 12'h000;
            ramp_dn_q  <= 1'b0;
        end else if (!step_done) begin
            hold_cnt_q <= hold_cnt_q + 6'h01; // R9
        end else begin
            hold_cnt_q <= 6'h00;
            case (shape_q)
                RAMP_UP:   ramp_q <= ramp_q + 12'h001; // R10
                RAMP_DOWN: ramp_q <= ramp_q - 12'h001;
                RAMP_TRI: begin
                    // turn round at either end of the range
                    if (ramp_dn_q) begin
                        ramp_q    <= ramp_q - 12'h001;
                        ramp_dn_q <= (ramp_q != 12'h001);
                    end else begin
                        ramp_q    <= ramp_q + 12'h001;
                        ramp_dn_q <= (ramp_q == 12'hffe);
                    end
                end
                default:   ramp_q <= 12'h000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // pseudorandom source
    // ------------------------------------------------------------------
    // maximal-length 16-bit Fibonacci register, taps 16 15 13 4
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            lfsr_q <= RST_LFSR;
        end else begin
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[14] ^ lfsr_q[12] ^ lfsr_q[3]};
        end
    end

    // ------------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------------
    // samples are two's complement; the ramp is centred by flipping its top bit
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            src_q <= 12'h000;
        end else begin
            case (prestore_q)
                PRE_CONST: src_q <= const_q; // R6 R7
                PRE_RAMP:  src_q <= (shape_q == RAMP_ZERO) ? 12'h000
                                    : {~ramp_q[11], ramp_q[10:0]}; // R10
                PRE_NOISE: src_q <= lfsr_q[11:0];
                PRE_SYNTH: src_q <= SYNTH_SAMPLE;
                default:   src_q <= 12'h000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // digital gain
    // ------------------------------------------------------------------
    // gain of zero after reset silences the output until software sets it
    assign product = 24'($signed(src_q) * $signed(gain_q));
    assign scaled  = product[GAIN_FRAC +: 14];

    always_comb begin
        // clip instead of wrapping when a gain above one overflows
        if (scaled[13] && !(&scaled[12:11])) begin
            sat_d = 12'h800;
        end else if (!scaled[13] && (|scaled[12:11])) begin
            sat_d = 12'h7ff;
        end else begin
            sat_d = scaled[11:0];
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            SAMPLE_OUT <= 12'h000;
        end else begin
            SAMPLE_OUT <= sat_d; // R8
        end
    end

    // ------------------------------------------------------------------
    // synthesizer control words
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            SYNTH_CTRL <= '0;
        end else begin
            SYNTH_CTRL.tuning_word  <= {tw_hi_q, tw_lo_q}; // R11 R12
            SYNTH_CTRL.phase_offset <= phase_q; // R13
        end
    end

endmodule

// ### test/wavegen_cfg_props.sv
// assertion checker for the waveform generator config bank
`timescale 1ns/10ps
module wavegen_cfg_props (
    input wire logic                         CLOCK,
    input wire logic                         RST_B,
    input wire wavegen_cfg_pkg::reg_req_t    REG_REQ,
    input wire logic [15:0]                  RDATA,
    input wire logic                         TRIGGER_B,
    input wire logic                         PATTERN_END,
    input wire wavegen_cfg_pkg::synth_ctrl_t SYNTH_CTRL,
    input wire logic                         START_DELAY_EN,
    input wire logic                         MARKER_OUT,
    input wire logic                         MARKER_OE
);
    import wavegen_cfg_pkg::*;
    logic        mode_q;   // shadow of marker mode
    logic        first_q;  // shadow of first-pattern-only bit
    logic [3:0]  stop_q;   // shadow of stop delay
    logic [15:0] start_q;  // shadow of start delay
    // shadows follow bus writes so timing checks know the programmed counts
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            {mode_q, first_q, stop_q, start_q} <= {2'b00, 4'h0, 16'h0003};
        end else if (REG_REQ.wr) begin
            if (REG_REQ.addr == OFS_MARK_CFG) {mode_q, stop_q} <= REG_REQ.wdata[4:0];
            if (REG_REQ.addr == OFS_MARK_START) start_q <= REG_REQ.wdata;
            if (REG_REQ.addr == OFS_PAT_CTRL) first_q <= REG_REQ.wdata[1];
        end
    end
    // --------------------------------------------------------------
    // properties
    // --------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    rdata_idle_a: assert property (!$past(REG_REQ.rd) |-> RDATA == 16'h0)
        else $error("read data not idle");
    manual_level_a: assert property (
        REG_REQ.wr && REG_REQ.addr == OFS_MARK_CFG && !REG_REQ.wdata[4] ##1
        !REG_REQ.wr && MARKER_OE |=> MARKER_OUT == $past(REG_REQ.wdata[5], 2))
        else $error("manual marker level wrong");
    marker_off_a: assert property (!MARKER_OE |=> !MARKER_OUT)
        else $error("marker high while disabled");
    stop_delay_a: assert property (
        PATTERN_END && MARKER_OUT && MARKER_OE && mode_q && TRIGGER_B && stop_q == 4'h2
        |-> MARKER_OUT[*5] ##1 !MARKER_OUT) else $error("stop delay wrong");
    start_delay_a: assert property (
        $fell(TRIGGER_B) && mode_q && MARKER_OE && start_q == 16'h4
        |-> !MARKER_OUT[*6] ##[1:5] MARKER_OUT) else $error("start delay wrong");
    tw_hi_a: assert property (REG_REQ.wr && REG_REQ.addr == OFS_TW_HI |->
        ##2 SYNTH_CTRL.tuning_word[23:8] == $past(REG_REQ.wdata, 2)) else $error("tw hi");
    tw_lo_a: assert property (REG_REQ.wr && REG_REQ.addr == OFS_TW_LO |->
        ##2 SYNTH_CTRL.tuning_word[7:0] == $past(REG_REQ.wdata[15:8], 2)) else $error("tw lo");
    phase_a: assert property (REG_REQ.wr && REG_REQ.addr == OFS_PHASE |->
        ##2 SYNTH_CTRL.phase_offset == $past(REG_REQ.wdata, 2)) else $error("phase");
    every_pattern_a: assert property (!first_q |-> START_DELAY_EN)
        else $error("start delay not on every pattern");
    cover property (MARKER_OE && $rose(MARKER_OUT));
    cover property (first_q && $fell(START_DELAY_EN));
    cover property (REG_REQ.rd && REG_REQ.addr == OFS_SAW);
endmodule
bind waveform_gen_config_regs wavegen_cfg_props u_wavegen_cfg_props (.CLOCK, .RST_B,
    .REG_REQ, .RDATA, .TRIGGER_B, .PATTERN_END, .SYNTH_CTRL, .START_DELAY_EN,
    .MARKER_OUT, .MARKER_OE);

// ### test/waveform_gen_config_regs_bench.sv
// self-checking bench of the waveform generator config bank
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module waveform_gen_config_regs_bench;
    import wavegen_cfg_pkg::*;
    logic        CLOCK = 0, RST_B = 0, TRIGGER_B = 1, PATTERN_END = 0;
    reg_req_t    REG_REQ = '0;
    logic [11:0] SYNTH_SAMPLE = 12'h100, SAMPLE_OUT;
    logic [15:0] RDATA, rd_v;
    synth_ctrl_t SYNTH_CTRL;
    logic        START_DELAY_EN, MARKER_OUT, MARKER_OE;
    int          mismatches = 0, check_count = 0, n;
    always #2 CLOCK = ~CLOCK;
    waveform_gen_config_regs u_waveform_gen_config_regs (.CLOCK, .RST_B, .REG_REQ, .RDATA,
        .TRIGGER_B, .PATTERN_END, .SYNTH_SAMPLE, .SAMPLE_OUT, .SYNTH_CTRL,
        .START_DELAY_EN, .MARKER_OUT, .MARKER_OE);
    // bus cycles: strobe for one cycle, read data taken the cycle after
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge CLOCK) REG_REQ <= '{a, d, 1'b1, 1'b0};
        @(posedge CLOCK) REG_REQ.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge CLOCK) REG_REQ <= '{a, 16'h0, 1'b0, 1'b1};
        @(posedge CLOCK) REG_REQ.rd <= 1'b0;
        #1 rd_v = RDATA;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge CLOCK);
        #1;
    endtask
    task automatic t_regs;
        rd(OFS_MARK_START); `CHK(rd_v, 16'h0003)
        rd(OFS_SAW); `CHK(rd_v, 16'h0004)
        `CHK(START_DELAY_EN, 1'b1)
        wr(OFS_CONST, 16'habcf); rd(OFS_CONST); `CHK(rd_v, 16'habc0)
        wr(OFS_SAW, 16'hffff); rd(OFS_SAW); `CHK(rd_v, 16'h00ff)
        wr(OFS_TW_LO, 16'h5a77); rd(OFS_TW_LO); `CHK(rd_v, 16'h5a00)
        wr(OFS_TW_HI, 16'h1234); wr(OFS_PHASE, 16'hbeef); cyc(2);
        `CHK(SYNTH_CTRL, {24'h12345a, 16'hbeef})
        wr(8'h7f, 16'hffff); rd(8'h7f); `CHK(rd_v, 16'h0)
        $display("register test done");
    endtask
    // selector and gain table; constant is 0xabc, synth sample 0x100
    task automatic t_gain;
        logic [1:0]  sel[6] = '{2'd0, 2'd0, 2'd3, 2'd3, 2'd1, 2'd2};
        logic [15:0] g[6] = '{16'h4000, 16'h8000, 16'h8000, 16'h7ff0, 16'h4000, 16'h0};
        logic [11:0] e[6] = '{12'habc, 12'h7ff, 12'he00, 12'h1ff, 12'h0, 12'h0};
        for (int i = 0; i < 6; i++) begin
            wr(OFS_WAVE_SEL, {10'h0, sel[i], 4'h0});
            wr(OFS_GAIN, g[i]);
            cyc(3);
            `CHK(SAMPLE_OUT, e[i])
        end
        $display("gain test done");
    endtask
    task automatic t_manual;
        wr(OFS_MAIN_CTRL, 16'h1); wr(OFS_MARK_CFG, 16'h0020); cyc(2);
        `CHK({MARKER_OE, MARKER_OUT}, 2'b11)
        wr(OFS_MARK_CFG, 16'h0030); cyc(2); `CHK(MARKER_OUT, 1'b0)
        wr(OFS_MARK_CFG, 16'h0020); wr(OFS_MAIN_CTRL, 16'h0); cyc(2);
        `CHK({MARKER_OE, MARKER_OUT}, 2'b00)
        wr(OFS_MARK_CFG, 16'h0000);
        $display("manual marker test done");
    endtask
    // timed marker: start delay 4, stop delay 2, delay before first pattern only
    task automatic t_timed;
        wr(OFS_MAIN_CTRL, 16'h1); wr(OFS_MARK_START, 16'h4);
        wr(OFS_PAT_CTRL, 16'h2); wr(OFS_MARK_CFG, 16'h0012); cyc(2);
        `CHK(START_DELAY_EN, 1'b0)
        @(posedge CLOCK) TRIGGER_B <= 1'b0;
        for (n = 0; n < 20 && MARKER_OUT !== 1'b1; n++) cyc(1);
        `CHK(n >= 6 && n <= 10, 1'b1)
        `CHK(START_DELAY_EN, 1'b1)
        rd(OFS_STATUS); `CHK(rd_v, 16'h001d)
        @(posedge CLOCK) TRIGGER_B <= 1'b1;
        cyc(4);
        @(posedge CLOCK) PATTERN_END <= 1'b1;
        @(posedge CLOCK) PATTERN_END <= 1'b0;
        for (n = 0; n < 12 && MARKER_OUT !== 1'b0; n++) cyc(1);
        `CHK(n >= 2 && n <= 5, 1'b1)
        `CHK(START_DELAY_EN, 1'b0)
        $display("timed marker test done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge CLOCK);
        RST_B <= 1'b1;
        t_regs; t_gain; t_manual; t_timed;
        wrap_up;
    end
    // the tests need well under 1000 cycles
    initial begin
        #20000;
        mismatches++;
        wrap_up;
    end
endmodule
